// *** pkg/scd_regs.svh ***
// Pin encodings, field positions and counts of the command decoder.
// Assumes nothing; holds definitions only.
`ifndef SCD_REGS_SVH
`define SCD_REGS_SVH
// Command code {cs#, ras#, cas#, we#}.
`define SCD_ENC_ACT 4'h3
`define SCD_ENC_PRE 4'h2
`define SCD_ENC_WR 4'h4
`define SCD_ENC_RD 4'h5
`define SCD_ENC_MRS 4'h0
`define SCD_ENC_REF 4'h1
`define SCD_ENC_NOP 4'h7
`define SCD_ENC_ZQ 4'h6
// Address field positions.
`define SCD_COL_MSB 9
`define SCD_AP_BIT 10
`define SCD_BC_BIT 12
// Burst length field of mode register zero and its codes.
`define SCD_BL_MSB 1
`define SCD_BL_LSB 0
`define SCD_BL_FIXED8 2'h0
`define SCD_BL_OTF 2'h1
`define SCD_BL_FIXED4 2'h2
// Mode register selects on the bank address.
`define SCD_MR_ZERO 3'h0
`define SCD_MR_ONE 3'h1
`define SCD_MR_TWO 3'h2
// Beats per burst.
`define SCD_BEATS_FOUR 4'h4
`define SCD_BEATS_EIGHT 4'h8
// Clock cycles after reset before the pin samplers and delay flops hold real levels.
`define SCD_FILL_DONE 2'h3
`endif

// *** pkg/scd_pkg.sv ***
// Types shared by the command decoder.
// Assumes the encodings of scd_regs.svh.
package scd_pkg;
  typedef enum logic [3:0] {
    SCD_C_NONE = 4'h0,
    SCD_C_ACT = 4'h1,
    SCD_C_PRE = 4'h2,
    SCD_C_PREA = 4'h3,
    SCD_C_WR = 4'h4,
    SCD_C_RD = 4'h5,
    SCD_C_MRS = 4'h6,
    SCD_C_REF = 4'h7,
    SCD_C_ZQL = 4'h8,
    SCD_C_ZQS = 4'h9
  } scd_cmd_t;
  typedef enum logic [1:0] {
    SCD_P_RUN = 2'h0,
    SCD_P_PDN = 2'h1,
    SCD_P_SREF = 2'h2
  } scd_pwr_t;
endpackage : scd_pkg

// *** logic/scd_decoder.sv ***
// Command decoder and pin control of a sixteen-bit eight-bank DDR memory.
// Assumes the memory clock and data strobe are far slower than clk_i, so the
// two-flop samplers see every level; pins are stable around clock edges.
// Summary of operation
// - Sixteen data lines move on both strobe edges.
// - Masked byte discarded, unmasked byte stored.
// - Lower and upper masks gate own lanes.
// - Registered termination input enables lane termination.
// - Termination input ignored when both fields disabled.
// - Reset pin low asynchronously holds reset.
// - Write decode, auto precharge, fixed burst mode.
// - On-the-fly chop bit selects four or eight.
// - Read decode, same precharge and chop.
// - All strobes low: mode register set.
// - Clock enable change enters or exits low power.
// - Activate opens addressed bank with row.
// - Precharge one bank or all banks.
// - Chip select high means deselect.
// - Column from ten bits, row thirteen.
`timescale 1ns/100ps
`include "scd_regs.svh"
module scd_decoder #(
  parameter int ROW_W = 13,
  parameter int DQ_W = 16,
  parameter logic [12:0] RTT1_MASK = 13'h0244,
  parameter logic [12:0] RTT2_MASK = 13'h0600
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reset_n_i,
  input wire logic ck_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [2:0] ba_i,
  input wire logic [ROW_W-1:0] addr_i,
  input wire logic odt_i,
  input wire logic lower_byte_mask_i,
  input wire logic upper_byte_mask_i,
  input wire logic dqs_i,
  output logic dqs_o,
  output logic dqs_oe_o,
  input wire logic [DQ_W-1:0] dq_i,
  output logic [DQ_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic term_on_o,
  output scd_pkg::scd_cmd_t cmd_o,
  output logic cmd_valid_o,
  output logic [2:0] cmd_bank_o,
  output logic [ROW_W-1:0] cmd_addr_o,
  output logic cmd_chop_o,
  output logic [7:0] bank_open_o,
  output scd_pkg::scd_pwr_t pwr_o,
  output logic [DQ_W-1:0] wr_data_o,
  output logic [1:0] wr_byte_en_o,
  output logic wr_valid_o,
  input wire logic [DQ_W-1:0] rd_data_i,
  input wire logic rd_valid_i,
  output logic rd_ready_o
);
  localparam int SW = 13 + ROW_W + DQ_W;

  // ***************************************************************
  // Reset and pin sampling
  // ***************************************************************
  // The reset pin acts without the clock, as the memory's own reset does.
  logic arst;
  assign arst = rst_i | ~reset_n_i;

  logic [SW-1:0] pin_s1_reg, pin_s2_reg;
  logic ck_d_reg, dqs_d_reg;
  logic [1:0] fill_reg;
  always_ff @(posedge clk_i or posedge arst) begin
    if (arst) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else begin
      pin_s1_reg <= {ck_i, dqs_i, cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, odt_i,
                     lower_byte_mask_i, upper_byte_mask_i, ba_i, addr_i, dq_i};
      pin_s2_reg <= pin_s1_reg;
    end
  end
  logic ck_s, dqs_s, cke_s, odt_s, ldm_s, udm_s;
  logic [3:0] enc_s;
  logic [2:0] ba_s;
  logic [ROW_W-1:0] addr_s;
  logic [DQ_W-1:0] dq_s;
  assign {ck_s, dqs_s, cke_s, enc_s, odt_s, ldm_s, udm_s, ba_s, addr_s, dq_s} =
         pin_s2_reg;

  always_ff @(posedge clk_i or posedge arst) begin
    if (arst) begin
      ck_d_reg <= 1'b0;
      dqs_d_reg <= 1'b0;
      fill_reg <= 2'h0;
    end else begin
      ck_d_reg <= ck_s;
      dqs_d_reg <= dqs_s;
      if (fill_reg != `SCD_FILL_DONE) begin
        fill_reg <= fill_reg + 2'h1;
      end
    end
  end
  // Edges count only once samplers and delay flops hold real pin levels, so a
  // pin that is high at reset release does not look like an edge.
  logic primed;
  assign primed = (fill_reg == `SCD_FILL_DONE);
  logic ck_rise, ck_edge, dqs_edge;
  assign ck_rise = primed & ck_s & ~ck_d_reg;
  assign ck_edge = primed & (ck_s ^ ck_d_reg);
  assign dqs_edge = primed & (dqs_s ^ dqs_d_reg);

  // ***************************************************************
  // Command decode
  // ***************************************************************
  logic cke_prev_reg;
  logic [1:0] bl_mode_reg;
  logic rtt1_on_reg, rtt2_on_reg;
  scd_pkg::scd_pwr_t pwr_reg;
  scd_pkg::scd_cmd_t dec;
  logic run, chop;
  assign run = cke_prev_reg & cke_s;

  always_comb begin
    dec = scd_pkg::SCD_C_NONE;
    if (run && !enc_s[3]) begin
      case (enc_s)
        `SCD_ENC_ACT: dec = scd_pkg::SCD_C_ACT;
        `SCD_ENC_PRE: dec = addr_s[`SCD_AP_BIT] ? scd_pkg::SCD_C_PREA
                                                : scd_pkg::SCD_C_PRE;
        `SCD_ENC_WR: dec = scd_pkg::SCD_C_WR;
        `SCD_ENC_RD: dec = scd_pkg::SCD_C_RD;
        `SCD_ENC_MRS: dec = scd_pkg::SCD_C_MRS;
        `SCD_ENC_REF: dec = scd_pkg::SCD_C_REF;
        `SCD_ENC_ZQ: dec = addr_s[`SCD_AP_BIT] ? scd_pkg::SCD_C_ZQL
                                               : scd_pkg::SCD_C_ZQS;
        default: dec = scd_pkg::SCD_C_NONE;
      endcase
    end
  end

  // Fixed modes ignore the chop bit; on the fly a low bit chops.
  assign chop = (bl_mode_reg == `SCD_BL_FIXED4) ||
                ((bl_mode_reg == `SCD_BL_OTF) && !addr_s[`SCD_BC_BIT]);

  // Mode set and calibration are only taken while every bank is idle.
  logic idle_ok, take;
  assign idle_ok = (bank_open_o == 8'h00);
  assign take = ck_rise && dec != scd_pkg::SCD_C_NONE &&
                !((dec == scd_pkg::SCD_C_MRS || dec == scd_pkg::SCD_C_ZQL ||
                   dec == scd_pkg::SCD_C_ZQS) && !idle_ok);

  always_ff @(posedge clk_i or posedge arst) begin
    if (arst) begin
      cmd_o <= scd_pkg::SCD_C_NONE;
      cmd_valid_o <= 1'b0;
      cmd_bank_o <= 3'h0;
      cmd_addr_o <= '0;
      cmd_chop_o <= 1'b0;
    end else begin
      cmd_valid_o <= take;
      if (take) begin
        cmd_o <= dec;
        cmd_bank_o <= ba_s;
        cmd_chop_o <= chop;
        if (dec == scd_pkg::SCD_C_WR || dec == scd_pkg::SCD_C_RD) begin
          cmd_addr_o <= '0;
          cmd_addr_o[`SCD_COL_MSB:0] <= addr_s[`SCD_COL_MSB:0];
          cmd_addr_o[`SCD_AP_BIT] <= addr_s[`SCD_AP_BIT];
        end else begin
          cmd_addr_o <= addr_s;
        end
      end
    end
  end

  // Bank state is kept for the consumer; the controller keeps the order.
  always_ff @(posedge clk_i or posedge arst) begin
    if (arst) begin
      bank_open_o <= 8'h00;
    end else if (take) begin
      case (dec)
        scd_pkg::SCD_C_ACT: bank_open_o[ba_s] <= 1'b1;
        scd_pkg::SCD_C_PRE: bank_open_o[ba_s] <= 1'b0;
        scd_pkg::SCD_C_PREA: bank_open_o <= 8'h00;
        scd_pkg::SCD_C_WR, scd_pkg::SCD_C_RD: begin
          if (addr_s[`SCD_AP_BIT]) begin
            bank_open_o[ba_s] <= 1'b0;
          end
        end
        default: bank_open_o <= bank_open_o;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge arst) begin
    if (arst) begin
      bl_mode_reg <= `SCD_BL_FIXED8;
      rtt1_on_reg <= 1'b0;
      rtt2_on_reg <= 1'b0;
    end else if (take && dec == scd_pkg::SCD_C_MRS) begin
      case (ba_s)
        `SCD_MR_ZERO: bl_mode_reg <= addr_s[`SCD_BL_MSB:`SCD_BL_LSB];
        `SCD_MR_ONE: rtt1_on_reg <= |(addr_s & RTT1_MASK);
        `SCD_MR_TWO: rtt2_on_reg <= |(addr_s & RTT2_MASK);
        default: bl_mode_reg <= bl_mode_reg;
      endcase
    end
  end

  // ***************************************************************
  // Power states and termination
  // ***************************************************************
  always_ff @(posedge clk_i or posedge arst) begin
    if (arst) begin
      cke_prev_reg <= 1'b0;
      pwr_reg <= scd_pkg::SCD_P_RUN;
    end else if (ck_rise) begin
      cke_prev_reg <= cke_s;
      if (cke_prev_reg && !cke_s) begin
        pwr_reg <= (!enc_s[3] && enc_s == `SCD_ENC_REF) ? scd_pkg::SCD_P_SREF
                                                        : scd_pkg::SCD_P_PDN;
      end else if (!cke_prev_reg && cke_s) begin
        pwr_reg <= scd_pkg::SCD_P_RUN;
      end
    end
  end
  assign pwr_o = pwr_reg;

  // Disabling both fields drops termination at once, not at the next clock rise.
  always_ff @(posedge clk_i or posedge arst) begin
    if (arst) begin
      term_on_o <= 1'b0;
    end else if (!rtt1_on_reg && !rtt2_on_reg) begin
      term_on_o <= 1'b0;
    end else if (ck_rise) begin
      term_on_o <= odt_s;
    end
  end

  // ***************************************************************
  // Data bursts
  // ***************************************************************
  logic [3:0] wr_left_reg, rd_left_reg;
  logic [3:0] beats;
  assign beats = chop ? `SCD_BEATS_FOUR : `SCD_BEATS_EIGHT;

  always_ff @(posedge clk_i or posedge arst) begin
    if (arst) begin
      wr_left_reg <= 4'h0;
      wr_valid_o <= 1'b0;
      wr_data_o <= '0;
      wr_byte_en_o <= 2'h0;
    end else begin
      wr_valid_o <= 1'b0;
      if (take && dec == scd_pkg::SCD_C_WR) begin
        wr_left_reg <= beats;
      end else if (wr_left_reg != 4'h0 && dqs_edge) begin
        wr_left_reg <= wr_left_reg - 4'h1;
        wr_valid_o <= 1'b1;
        wr_data_o <= dq_s;
        wr_byte_en_o <= {~udm_s, ~ldm_s};
      end
    end
  end

  // Two-entry read buffer: the user may run ahead by two words.
  logic [DQ_W-1:0] buf_reg [2];
  logic [1:0] cnt_reg;
  logic wp_reg, rp_reg, pop;
  assign rd_ready_o = (cnt_reg != 2'h2);
  assign pop = (rd_left_reg != 4'h0) && ck_edge && (cnt_reg != 2'h0);

  always_ff @(posedge clk_i or posedge arst) begin
    if (arst) begin
      buf_reg[0] <= '0;
      buf_reg[1] <= '0;
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (rd_valid_i && rd_ready_o) begin
        buf_reg[wp_reg] <= rd_data_i;
        wp_reg <= ~wp_reg;
      end
      if (pop) begin
        rp_reg <= ~rp_reg;
      end
      cnt_reg <= cnt_reg + {1'b0, rd_valid_i && rd_ready_o} - {1'b0, pop};
    end
  end

  // An empty buffer stalls the burst rather than sending stale data.
  always_ff @(posedge clk_i or posedge arst) begin
    if (arst) begin
      rd_left_reg <= 4'h0;
      dq_o <= '0;
      dq_oe_o <= 1'b0;
      dqs_o <= 1'b0;
      dqs_oe_o <= 1'b0;
    end else begin
      if (take && dec == scd_pkg::SCD_C_RD) begin
        rd_left_reg <= beats;
        dqs_o <= 1'b0;
      end else if (pop) begin
        rd_left_reg <= rd_left_reg - 4'h1;
        dq_o <= buf_reg[rp_reg];
        dqs_o <= ~dqs_o;
      end
      dq_oe_o <= (rd_left_reg != 4'h0);
      dqs_oe_o <= (rd_left_reg != 4'h0);
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  a_deselect_quiet: assert property (@(posedge clk_i) disable iff (arst)
    (ck_rise && enc_s[3]) |=> !cmd_valid_o) else $error("deselect decoded");
  a_mask_lanes: assert property (@(posedge clk_i) disable iff (arst)
    (wr_left_reg != 4'h0 && dqs_edge && !(take && dec == scd_pkg::SCD_C_WR))
    |=> wr_valid_o && wr_byte_en_o == {~$past(udm_s), ~$past(ldm_s)})
    else $error("mask lanes wrong");
  a_term_gate: assert property (@(posedge clk_i) disable iff (arst)
    !rtt1_on_reg && !rtt2_on_reg && $past(!rtt1_on_reg && !rtt2_on_reg) |-> !term_on_o)
    else $error("termination not gated");
  a_term_follow: assert property (@(posedge clk_i) disable iff (arst)
    (ck_rise && odt_s && rtt1_on_reg) |=> term_on_o) else $error("termination off");
  a_burst_len: assert property (@(posedge clk_i) disable iff (arst)
    (take && dec == scd_pkg::SCD_C_WR && bl_mode_reg == `SCD_BL_OTF)
    |=> wr_left_reg == ($past(addr_s[`SCD_BC_BIT]) ? `SCD_BEATS_EIGHT : `SCD_BEATS_FOUR))
    else $error("burst length wrong");
  a_fixed_len: assert property (@(posedge clk_i) disable iff (arst)
    (take && bl_mode_reg == `SCD_BL_FIXED8) |=> !cmd_chop_o) else $error("fixed chopped");
  a_act_open: assert property (@(posedge clk_i) disable iff (arst)
    (take && dec == scd_pkg::SCD_C_ACT) |=> bank_open_o[$past(ba_s)])
    else $error("bank not opened");
  a_prea_close: assert property (@(posedge clk_i) disable iff (arst)
    (take && dec == scd_pkg::SCD_C_PREA) |=> bank_open_o == 8'h00 ##1 cmd_o == scd_pkg::SCD_C_PREA)
    else $error("all banks not closed");
  a_sref_entry: assert property (@(posedge clk_i) disable iff (arst)
    (ck_rise && cke_prev_reg && !cke_s && enc_s == `SCD_ENC_REF)
    |=> pwr_o == scd_pkg::SCD_P_SREF) else $error("self refresh missed");
  a_mrs_idle: assert property (@(posedge clk_i) disable iff (arst)
    (cmd_valid_o && cmd_o == scd_pkg::SCD_C_MRS) |-> $past(idle_ok))
    else $error("mode set while active");
endmodule : scd_decoder

// *** testbench/scd_ctrl_model.sv ***
// Memory controller model that drives the decoder's command and data pins.
// Assumes clk_i is the bench clock; the link clock made here runs free.
`timescale 1ns/100ps
`include "scd_regs.svh"
module scd_ctrl_model (
  input wire logic clk_i
);
  logic ck = 1'b0;
  logic cke = 1'b1;
  logic reset_n = 1'b1;
  logic odt = 1'b0;
  logic dqs = 1'b0;
  logic [1:0] dm = 2'h0;
  logic [2:0] ba = 3'h0;
  logic [3:0] pins = `SCD_ENC_NOP;
  logic [12:0] addr = 13'h0000;
  logic [15:0] dq = 16'h0000;
  initial begin
    forever #62.5 ck = ~ck;
  end
  // Pins move half a link period away from the sampling rise, so no edge sees a change.
  task automatic cmd(input logic [3:0] p, input logic [2:0] b, input logic [12:0] a);
    @(negedge ck);
    @(posedge clk_i);
    pins <= p;
    ba <= b;
    addr <= a;
    @(negedge ck);
    @(posedge clk_i);
    pins <= `SCD_ENC_NOP;
    ba <= ~b;
    addr <= ~a;
  endtask : cmd
  // Data is scrambled once its hold time has run out, so a late capture shows.
  task automatic beat(input logic [15:0] d, input logic [1:0] m);
    @(posedge clk_i);
    dq <= d;
    dm <= m;
    repeat (3) @(posedge clk_i);
    dqs <= ~dqs;
    repeat (6) @(posedge clk_i);
    dq <= ~d;
  endtask : beat
endmodule : scd_ctrl_model

// *** testbench/test_sdram_command_decoder.sv ***
// Self-checking bench of the command decoder.
// Assumes scd_ctrl_model drives the pins; the read side is fed from here.
`timescale 1ns/100ps
`include "scd_regs.svh"
module test_sdram_command_decoder;
  typedef struct packed {
    scd_pkg::scd_cmd_t c;
    logic [2:0] b;
    logic [12:0] a;
    logic ch;
  } scd_exp_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd_valid = 1'b0;
  logic dqs_o, dqs_oe, dq_oe, term_on, cmd_valid, cmd_chop, wr_valid, rd_ready;
  logic dqs_prev = 1'b0;
  logic [1:0] wr_be;
  logic [2:0] cmd_bank;
  logic [7:0] bank_open;
  logic [12:0] cmd_addr, row, col;
  logic [15:0] dq_o, wr_data, rd_data = 16'h0000;
  scd_pkg::scd_cmd_t cmd;
  scd_pkg::scd_pwr_t pwr;
  int err_total = 0;
  int checks = 0;
  scd_exp_t cq[$];
  logic [17:0] wq[$];
  logic [15:0] rq[$];
  scd_ctrl_model ctl (
    .clk_i(clk)
  );
  wire dqs_w = dqs_oe ? dqs_o : ctl.dqs;
  wire [15:0] dq_w = dq_oe ? dq_o : ctl.dq;
  scd_decoder DUT (
    .clk_i(clk), .rst_i(rst), .reset_n_i(ctl.reset_n), .ck_i(ctl.ck), .cke_i(ctl.cke),
    .cs_n_i(ctl.pins[3]), .ras_n_i(ctl.pins[2]), .cas_n_i(ctl.pins[1]), .we_n_i(ctl.pins[0]),
    .ba_i(ctl.ba), .addr_i(ctl.addr), .odt_i(ctl.odt), .lower_byte_mask_i(ctl.dm[0]),
    .upper_byte_mask_i(ctl.dm[1]), .dqs_i(dqs_w), .dqs_o(dqs_o), .dqs_oe_o(dqs_oe),
    .dq_i(dq_w), .dq_o(dq_o), .dq_oe_o(dq_oe), .term_on_o(term_on), .cmd_o(cmd),
    .cmd_valid_o(cmd_valid), .cmd_bank_o(cmd_bank), .cmd_addr_o(cmd_addr),
    .cmd_chop_o(cmd_chop), .bank_open_o(bank_open), .pwr_o(pwr), .wr_data_o(wr_data),
    .wr_byte_en_o(wr_be), .wr_valid_o(wr_valid), .rd_data_i(rd_data),
    .rd_valid_i(rd_valid), .rd_ready_o(rd_ready)
  );
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  // Reads and writes report only the column and the precharge bit.
  task automatic go(input logic [3:0] p, input logic [2:0] b, input logic [12:0] a,
      input scd_pkg::scd_cmd_t c, input logic ch = 1'b0);
    if (c inside {scd_pkg::SCD_C_WR, scd_pkg::SCD_C_RD}) begin
      cq.push_back('{c, b, a & 13'h07ff, ch});
    end else if (c != scd_pkg::SCD_C_NONE) begin
      cq.push_back('{c, b, a, ch});
    end
    ctl.cmd(p, b, a);
  endtask : go
  task automatic wburst(input int n);
    logic [15:0] d;
    logic [1:0] m;
    for (int i = 0; i < n; i++) begin
      d = 16'($urandom);
      m = i[1:0];
      wq.push_back({~m, d});
      ctl.beat(d, m);
    end
  endtask : wburst
  // Random one-cycle gaps vary the pace; the buffer refills long before the next beat.
  task automatic rpush(input int n);
    logic [15:0] w;
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      w = 16'($urandom);
      rq.push_back(w);
      rd_data <= w;
      rd_valid <= 1'b1;
      do @(posedge clk); while (rd_ready !== 1'b1);
      if ($urandom_range(1) == 1) begin
        rd_valid <= 1'b0;
        @(posedge clk);
      end
    end
    rd_valid <= 1'b0;
  endtask : rpush
  task automatic lowp(input logic [3:0] p, input scd_pkg::scd_pwr_t e);
    @(negedge ctl.ck);
    @(posedge clk);
    ctl.cke <= 1'b0;
    ctl.pins <= p;
    @(negedge ctl.ck);
    @(posedge clk);
    ctl.pins <= `SCD_ENC_NOP;
    @(negedge ctl.ck);
    chk(pwr, e);
    @(posedge clk);
    ctl.cke <= 1'b1;
    repeat (2) @(negedge ctl.ck);
    chk(pwr, scd_pkg::SCD_P_RUN);
  endtask : lowp
  always @(posedge clk) begin
    scd_exp_t e;
    logic [17:0] w;
    logic [15:0] m;
    if (cmd_valid === 1'b1) begin
      e = '1;
      if (cq.size() > 0) e = cq.pop_front();
      chk({cmd, cmd_bank, cmd_addr}, {e.c, e.b, e.a});
      if (e.c inside {scd_pkg::SCD_C_WR, scd_pkg::SCD_C_RD}) chk(cmd_chop, e.ch);
    end
    if (wr_valid === 1'b1) begin
      w = '1;
      if (wq.size() > 0) w = wq.pop_front();
      m = {{8{w[17]}}, {8{w[16]}}};
      chk({wr_be, wr_data & m}, {w[17:16], w[15:0] & m});
    end
    if (dqs_oe === 1'b1 && dqs_o !== dqs_prev) begin
      chk({dq_oe, dq_o}, {1'b1, rq.size() > 0 ? rq.pop_front() : ~dq_o});
    end
    dqs_prev <= dqs_o;
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    void'($urandom(32'h123cc914));
    row = 13'($urandom);
    col = 13'($urandom) & 13'h03ff;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    ctl.odt <= 1'b1;
    repeat (3) @(posedge ctl.ck);
    chk(term_on, 1'b0);
    go(`SCD_ENC_ACT, 3'h3, row, scd_pkg::SCD_C_ACT);
    chk(bank_open, 8'h08);
    go(`SCD_ENC_WR, 3'h3, col, scd_pkg::SCD_C_WR);
    wburst(8);
    go(`SCD_ENC_PRE, 3'h3, 13'h0000, scd_pkg::SCD_C_PRE);
    go(`SCD_ENC_MRS, 3'h0, 13'h0001, scd_pkg::SCD_C_MRS);
    go(`SCD_ENC_MRS, 3'h1, 13'h0004, scd_pkg::SCD_C_MRS);
    repeat (2) @(posedge ctl.ck);
    chk(term_on, 1'b1);
    go(4'hb, 3'h5, row, scd_pkg::SCD_C_NONE);
    go(`SCD_ENC_ACT, 3'h5, ~row, scd_pkg::SCD_C_ACT);
    go(`SCD_ENC_MRS, 3'h0, 13'h0000, scd_pkg::SCD_C_NONE);
    go(`SCD_ENC_WR, 3'h5, col, scd_pkg::SCD_C_WR, 1'b1);
    wburst(4);
    rpush(2);
    @(posedge clk);
    #1 chk(rd_ready, 1'b0);
    fork
      go(`SCD_ENC_RD, 3'h5, col | 13'h1400, scd_pkg::SCD_C_RD);
      rpush(6);
    join
    repeat (6) @(posedge ctl.ck);
    chk(bank_open, 8'h00);
    go(`SCD_ENC_ZQ, 3'h0, 13'h0400, scd_pkg::SCD_C_ZQL);
    go(`SCD_ENC_ZQ, 3'h0, 13'h0000, scd_pkg::SCD_C_ZQS);
    go(`SCD_ENC_REF, 3'h0, 13'h0000, scd_pkg::SCD_C_REF);
    go(`SCD_ENC_MRS, 3'h0, 13'h0002, scd_pkg::SCD_C_MRS);
    go(`SCD_ENC_ACT, 3'h2, row, scd_pkg::SCD_C_ACT);
    // Fixed four-beat mode chops although the chop bit asks for eight.
    go(`SCD_ENC_WR, 3'h2, col | 13'h1000, scd_pkg::SCD_C_WR, 1'b1);
    wburst(4);
    @(posedge clk);
    ctl.reset_n <= 1'b0;
    @(posedge clk);
    #1 chk(bank_open, 8'h00);
    @(posedge clk);
    ctl.reset_n <= 1'b1;
    repeat (2) @(posedge ctl.ck);
    chk(term_on, 1'b0);
    go(`SCD_ENC_ACT, 3'h2, row, scd_pkg::SCD_C_ACT);
    go(`SCD_ENC_PRE, 3'h6, 13'h0400, scd_pkg::SCD_C_PREA);
    chk(bank_open, 8'h00);
    lowp(`SCD_ENC_NOP, scd_pkg::SCD_P_PDN);
    lowp(`SCD_ENC_REF, scd_pkg::SCD_P_SREF);
    chk(cq.size() + wq.size() + rq.size(), 0);
    end_of_test();
  end
  initial begin
    #100000;
    err_total++;
    end_of_test();
  end
endmodule : test_sdram_command_decoder
